//--- logic/cwd_pkg.sv
// shared constants for the instruction execution block
package cwd_pkg;
	// phases of one instruction cycle
	localparam logic [1:0] Q_DECODE = 2'h0;
	localparam logic [1:0] Q_WRITE = 2'h3;
	// operation words and patterns
	localparam logic [15:0] OPC_WD_CLEAR = 16'h0004;
	localparam logic [15:0] OPC_DEC_ADJ = 16'h0007;
	localparam logic [5:0] OPC_COMPL = 6'h07;
	localparam logic [6:0] OPC_CMP_LT = 7'h30;
	localparam logic [6:0] OPC_CMP_EQ = 7'h31;
	localparam logic [6:0] OPC_CMP_GT = 7'h32;
	localparam int D_BIT = 9;
	localparam int A_BIT = 8;
	localparam logic [7:0] ILO_LIMIT = 8'h5f;
	localparam logic [3:0] TOP_BANK = 4'hf;
	// bcd adjust
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] BCD_FIX = 4'h6;
	// status bit positions
	localparam int ST_C = 0;
	localparam int ST_HC = 1;
	localparam int ST_Z = 2;
	localparam int ST_OV = 3;
	localparam int ST_N = 4;
	// register byte offsets
	localparam logic [7:0] REG_INSTR = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_ACCUM = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_POWER = 8'h10;
	localparam logic [7:0] REG_BANK = 8'h14;
	localparam logic [7:0] REG_IBASE = 8'h18;
	localparam logic [7:0] REG_MADDR = 8'h1c;
	localparam logic [7:0] REG_MDATA = 8'h20;
	localparam logic [7:0] REG_STATE = 8'h24;
	// reset values
	localparam logic RST_EXPIRY = 1'b1;
	localparam logic RST_SLEEP = 1'b1;
	localparam logic [4:0] RST_STATUS = 5'h00;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_SKIP = 3'b100
	} cwd_state_t;
endpackage

//--- logic/cwd_file_mem.sv
// file register memory with registered read data
`timescale 1ns/1ns
module cwd_file_mem #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 12
)(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic we_i,
	input wire logic [DATA_W-1:0] wdata_i,
	output logic [DATA_W-1:0] rdata_o
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	generate
		if (DATA_W < 1 || ADDR_W < 1)
		begin : g_bad
			$error("cwd_file_mem: bad width");
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem[addr_i] <= wdata_i;
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rdata_o <= '0;
		else
			rdata_o <= mem[addr_i];
	end
endmodule // cwd_file_mem

//--- logic/cwd_bcd_adj.sv
// packed bcd correction of the accumulator
`timescale 1ns/1ns
module cwd_bcd_adj (
	input wire logic [7:0] acc_i,
	input wire logic carry_i,
	input wire logic half_carry_i,
	output logic [7:0] result_o,
	output logic carry_o
);
	logic [4:0] lo;
	logic [4:0] hi;

	always_comb
	begin
		lo = {1'b0, acc_i[3:0]};
		if (acc_i[3:0] > cwd_pkg::BCD_MAX || half_carry_i) // [RQ13]
			lo = lo + {1'b0, cwd_pkg::BCD_FIX};
		hi = {1'b0, acc_i[7:4]} + {4'h0, lo[4]};
		if (hi > {1'b0, cwd_pkg::BCD_MAX} || carry_i) // [RQ14]
			hi = hi + {1'b0, cwd_pkg::BCD_FIX};
		result_o = {hi[3:0], lo[3:0]};
		carry_o = carry_i | hi[4]; // [RQ14]
	end
endmodule // cwd_bcd_adj

//--- logic/cwd_exec_core.sv
// executes watchdog clear, complement, compare-skip and decimal adjust words
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
// Overview of operation
// RQ1: word 0004h zeroes the watchdog counter in one cycle, no operand.
// RQ2: watchdog clear also zeroes postscaler and sets expiry and sleep-entry flags.
// RQ3: complement word yields bitwise inverse of the addressed file register.
// RQ4: complement destination bit 0 writes accumulator, 1 writes file register back.
// RQ5: complement updates only negative and zero flags from its result.
// RQ6: access bit 0 picks access bank, 1 uses bank select register.
// RQ7: access bit 0 with extension on and address up to 5Fh uses indexed offset.
// RQ8: compare-equal skips next word when register equals accumulator.
// RQ9: compare-greater skips next word when register exceeds accumulator.
// RQ10: compare-less skips next word when register is below accumulator.
// RQ11: compares decide by unsigned subtraction and leave all flags untouched.
// RQ12: compares take 1 cycle, 2 when skipping, 3 when skipping a two-word.
// RQ13: decimal adjust adds 6 to low nibble above 9 or with half carry.
// RQ14: high nibble plus carry-in above 9 or carry set gets 6; overflow sets carry.
// RQ15: decimal adjust touches only carry, takes one cycle, writes accumulator.
module cwd_exec_core #(
	parameter int ADDR_W = 12,
	parameter logic [7:0] ACCESS_SPLIT = 8'h80
)(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic watchdog_clear_o,
	output logic postscaler_clear_o,
	output logic instr_done_o,
	output logic idle_slot_o,
	output logic busy_o
);
	typedef struct packed {
		cwd_pkg::cwd_state_t st;
		logic [1:0] q;
		logic pend;
		logic [15:0] instr;
		logic ext_en;
		logic two_word;
		logic [7:0] acc;
		logic [4:0] stat;
		logic expiry_flag;
		logic sleep_entry_flag;
		logic [3:0] bank_sel;
		logic [ADDR_W-1:0] ibase;
		logic [ADDR_W-1:0] maddr;
		logic [1:0] skip_left;
		logic skipped;
		logic [1:0] cycles;
		logic illegal;
		logic [7:0] result;
		logic wd_pulse;
		logic done;
		logic prev_idle;
		logic [31:0] rd;
	} cwd_core_t;

	cwd_core_t s_reg;
	cwd_core_t s_next;
	logic [ADDR_W-1:0] eff_addr;
	logic [ADDR_W-1:0] mem_addr;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic [7:0] adj_res;
	logic adj_c;
	logic [8:0] diff;
	logic cmp_lt;
	logic cmp_eq;
	logic cmp_gt;
	logic skip_hit;
	logic op_wd_clear;
	logic op_compl;
	logic op_cpeq;
	logic op_cpgt;
	logic op_cplt;
	logic op_cmp;
	logic op_dec_adj;
	logic is_idle;
	logic busy;
	logic setup;
	logic access;
	logic mapped;
	logic bad;
	logic wr_ok;
	logic [31:0] rd_mux;
	logic [7:0] f;

	generate
		if (ADDR_W < 12)
		begin : g_bad
			$error("cwd_exec_core: ADDR_W must hold bank and file address");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// decode

	assign f = s_reg.instr[7:0];
	assign op_wd_clear = s_reg.instr == cwd_pkg::OPC_WD_CLEAR; // [RQ1]
	assign op_dec_adj = s_reg.instr == cwd_pkg::OPC_DEC_ADJ;
	assign op_compl = s_reg.instr[15:10] == cwd_pkg::OPC_COMPL; // [RQ3]
	assign op_cpeq = s_reg.instr[15:9] == cwd_pkg::OPC_CMP_EQ; // [RQ8]
	assign op_cpgt = s_reg.instr[15:9] == cwd_pkg::OPC_CMP_GT; // [RQ9]
	assign op_cplt = s_reg.instr[15:9] == cwd_pkg::OPC_CMP_LT; // [RQ10]
	assign op_cmp = op_cpeq | op_cpgt | op_cplt;
	assign is_idle = s_reg.st == cwd_pkg::ST_IDLE;
	assign busy = !is_idle || s_reg.pend;

	// unsigned subtraction of accumulator from the register
	assign diff = {1'b0, mem_rdata} - {1'b0, s_reg.acc}; // [RQ11]
	assign cmp_lt = diff[8];
	assign cmp_eq = diff[7:0] == 8'h00;
	assign cmp_gt = !cmp_lt && !cmp_eq;
	assign skip_hit = (op_cpeq && cmp_eq) || (op_cpgt && cmp_gt) || (op_cplt && cmp_lt);

	always_comb
	begin
		if (s_reg.instr[cwd_pkg::A_BIT])
			eff_addr = ADDR_W'({s_reg.bank_sel, f}); // [RQ6]
		else if (s_reg.ext_en && f <= cwd_pkg::ILO_LIMIT)
			eff_addr = s_reg.ibase + ADDR_W'(f); // [RQ7]
		else if (f < ACCESS_SPLIT)
			eff_addr = ADDR_W'(f); // [RQ6]
		else
			eff_addr = ADDR_W'({cwd_pkg::TOP_BANK, f});
	end

	////////////////////////////////////////////////////////////////////////
	// file memory and bcd unit

	assign mem_addr = is_idle ? s_reg.maddr : eff_addr;
	assign mem_we = (s_reg.st == cwd_pkg::ST_EXEC && s_reg.q == cwd_pkg::Q_WRITE
		&& op_compl && s_reg.instr[cwd_pkg::D_BIT]) || (is_idle && wr_ok
		&& paddr_i == cwd_pkg::REG_MDATA); // [RQ4]
	assign mem_wdata = is_idle ? pwdata_i[7:0] : ~mem_rdata;

	cwd_file_mem #(
		.DATA_W(8),
		.ADDR_W(ADDR_W)
	) i_cwd_file_mem (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.addr_i(mem_addr),
		.we_i(mem_we),
		.wdata_i(mem_wdata),
		.rdata_o(mem_rdata)
	);

	cwd_bcd_adj i_cwd_bcd_adj (
		.acc_i(s_reg.acc),
		.carry_i(s_reg.stat[cwd_pkg::ST_C]),
		.half_carry_i(s_reg.stat[cwd_pkg::ST_HC]),
		.result_o(adj_res),
		.carry_o(adj_c)
	);

	////////////////////////////////////////////////////////////////////////
	// apb slave

	assign setup = psel_i && !penable_i;
	assign access = psel_i && penable_i;
	assign mapped = paddr_i <= cwd_pkg::REG_STATE && paddr_i[1:0] == 2'h0;
	assign bad = !mapped || (pwrite_i && paddr_i == cwd_pkg::REG_INSTR && busy)
		|| (paddr_i == cwd_pkg::REG_MDATA && (!is_idle || !s_reg.prev_idle))
		|| (pwrite_i && paddr_i == cwd_pkg::REG_STATE);
	assign wr_ok = access && pwrite_i && !bad;
	assign pready_o = 1'b1;
	assign pslverr_o = access && bad;
	assign prdata_o = (paddr_i == cwd_pkg::REG_MDATA) ? {24'h0, mem_rdata} : s_reg.rd;

	always_comb
	begin
		case (paddr_i)
			cwd_pkg::REG_INSTR: rd_mux = {16'h0, s_reg.instr};
			cwd_pkg::REG_CTRL: rd_mux = {30'h0, s_reg.two_word, s_reg.ext_en};
			cwd_pkg::REG_ACCUM: rd_mux = {24'h0, s_reg.acc};
			cwd_pkg::REG_STATUS: rd_mux = {27'h0, s_reg.stat};
			cwd_pkg::REG_POWER: rd_mux = {30'h0, s_reg.sleep_entry_flag, s_reg.expiry_flag};
			cwd_pkg::REG_BANK: rd_mux = {28'h0, s_reg.bank_sel};
			cwd_pkg::REG_IBASE: rd_mux = 32'(s_reg.ibase);
			cwd_pkg::REG_MADDR: rd_mux = 32'(s_reg.maddr);
			cwd_pkg::REG_STATE: rd_mux = {16'h0, s_reg.result, 3'h0, s_reg.illegal,
				s_reg.cycles, s_reg.skipped, busy};
			default: rd_mux = 32'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		s_next = s_reg;
		s_next.wd_pulse = 1'b0;
		s_next.done = 1'b0;
		s_next.prev_idle = is_idle;
		if (setup)
			s_next.rd = rd_mux;
		// software writes first so hardware updates below win
		if (wr_ok)
		begin
			case (paddr_i)
				cwd_pkg::REG_INSTR:
				begin
					s_next.instr = pwdata_i[15:0];
					s_next.pend = 1'b1;
				end
				cwd_pkg::REG_CTRL:
				begin
					s_next.ext_en = pwdata_i[0];
					s_next.two_word = pwdata_i[1];
				end
				cwd_pkg::REG_ACCUM: s_next.acc = pwdata_i[7:0];
				cwd_pkg::REG_STATUS: s_next.stat = pwdata_i[4:0];
				cwd_pkg::REG_POWER:
				begin
					s_next.expiry_flag = pwdata_i[0];
					s_next.sleep_entry_flag = pwdata_i[1];
				end
				cwd_pkg::REG_BANK: s_next.bank_sel = pwdata_i[3:0];
				cwd_pkg::REG_IBASE: s_next.ibase = pwdata_i[ADDR_W-1:0];
				cwd_pkg::REG_MADDR: s_next.maddr = pwdata_i[ADDR_W-1:0];
				default: s_next.pend = s_reg.pend;
			endcase
		end
		case (s_reg.st)
			cwd_pkg::ST_IDLE:
			begin
				if (s_reg.pend)
				begin
					s_next.st = cwd_pkg::ST_EXEC;
					s_next.q = cwd_pkg::Q_DECODE;
					s_next.pend = 1'b0;
				end
			end
			cwd_pkg::ST_EXEC:
			begin
				s_next.q = s_reg.q + 2'h1;
				if (s_reg.q == cwd_pkg::Q_WRITE)
				begin
					s_next.st = cwd_pkg::ST_IDLE;
					s_next.done = 1'b1;
					s_next.skipped = 1'b0;
					s_next.cycles = 2'h1;
					s_next.illegal = 1'b0;
					if (op_wd_clear)
					begin
						s_next.expiry_flag = 1'b1; // [RQ2]
						s_next.sleep_entry_flag = 1'b1; // [RQ2]
						s_next.wd_pulse = 1'b1; // [RQ1] [RQ2]
					end
					else if (op_compl)
					begin
						s_next.result = ~mem_rdata; // [RQ3]
						if (!s_reg.instr[cwd_pkg::D_BIT])
							s_next.acc = ~mem_rdata; // [RQ4]
						s_next.stat[cwd_pkg::ST_Z] = mem_rdata == 8'hff; // [RQ5]
						s_next.stat[cwd_pkg::ST_N] = ~mem_rdata[7]; // [RQ5]
					end
					else if (op_cmp)
					begin
						s_next.result = mem_rdata;
						if (skip_hit)
						begin
							s_next.st = cwd_pkg::ST_SKIP; // [RQ8] [RQ9] [RQ10]
							s_next.skipped = 1'b1;
							s_next.skip_left = s_reg.two_word ? 2'h2 : 2'h1; // [RQ12]
							s_next.cycles = s_reg.two_word ? 2'h3 : 2'h2; // [RQ12]
						end
					end
					else if (op_dec_adj)
					begin
						s_next.acc = adj_res; // [RQ15]
						s_next.result = adj_res;
						s_next.stat[cwd_pkg::ST_C] = adj_c; // [RQ15]
					end
					else
						s_next.illegal = 1'b1;
				end
			end
			cwd_pkg::ST_SKIP:
			begin
				// discarded words run as idle slots
				s_next.q = s_reg.q + 2'h1;
				if (s_reg.q == cwd_pkg::Q_WRITE)
				begin
					s_next.skip_left = s_reg.skip_left - 2'h1;
					if (s_reg.skip_left == 2'h1)
						s_next.st = cwd_pkg::ST_IDLE; // [RQ12]
				end
			end
			default: s_next.st = cwd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			s_reg <= '0;
			s_reg.st <= cwd_pkg::ST_IDLE;
			s_reg.stat <= cwd_pkg::RST_STATUS;
			s_reg.expiry_flag <= cwd_pkg::RST_EXPIRY;
			s_reg.sleep_entry_flag <= cwd_pkg::RST_SLEEP;
			s_reg.prev_idle <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign watchdog_clear_o = s_reg.wd_pulse;
	assign postscaler_clear_o = s_reg.wd_pulse;
	assign instr_done_o = s_reg.done;
	assign idle_slot_o = s_reg.st == cwd_pkg::ST_SKIP;
	assign busy_o = busy;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_wd_clear_flags: assert property (watchdog_clear_o |-> op_wd_clear && instr_done_o
		&& s_reg.expiry_flag && s_reg.sleep_entry_flag && postscaler_clear_o) // [RQ1] [RQ2]
		else $error("watchdog clear without flags");
	a_compl_value: assert property (instr_done_o && op_compl && !s_reg.instr[cwd_pkg::D_BIT]
		|-> s_reg.acc == ~$past(mem_rdata)) // [RQ3] [RQ4]
		else $error("complement result wrong");
	a_compl_flags: assert property (instr_done_o && op_compl |->
		s_reg.stat[cwd_pkg::ST_Z] == (s_reg.result == 8'h00)
		&& s_reg.stat[cwd_pkg::ST_N] == s_reg.result[7]
		&& s_reg.stat[cwd_pkg::ST_C] == $past(s_reg.stat[cwd_pkg::ST_C])) // [RQ5]
		else $error("complement flags wrong");
	a_bank_addr: assert property (s_reg.st == cwd_pkg::ST_EXEC && s_reg.instr[cwd_pkg::A_BIT]
		|-> mem_addr == ADDR_W'({s_reg.bank_sel, f})) // [RQ6]
		else $error("banked address wrong");
	a_index_addr: assert property (s_reg.st == cwd_pkg::ST_EXEC && !s_reg.instr[cwd_pkg::A_BIT]
		&& s_reg.ext_en && f <= cwd_pkg::ILO_LIMIT |-> mem_addr == s_reg.ibase + ADDR_W'(f)) // [RQ7]
		else $error("indexed address wrong");
	a_cmp_equal: assert property (instr_done_o && op_cpeq
		|-> s_reg.skipped == ($past(mem_rdata) == $past(s_reg.acc))) // [RQ8]
		else $error("equal skip wrong");
	a_cmp_greater: assert property (instr_done_o && op_cpgt
		|-> s_reg.skipped == ($past(mem_rdata) > $past(s_reg.acc))) // [RQ9]
		else $error("greater skip wrong");
	a_cmp_less: assert property (instr_done_o && op_cplt
		|-> s_reg.skipped == ($past(mem_rdata) < $past(s_reg.acc))) // [RQ10]
		else $error("less skip wrong");
	a_cmp_flags: assert property (instr_done_o && op_cmp |-> $stable(s_reg.stat)) // [RQ11]
		else $error("compare touched flags");
	a_skip_one: assert property (instr_done_o && s_reg.skipped && !s_reg.two_word
		|-> idle_slot_o [*4] ##1 !idle_slot_o) // [RQ12]
		else $error("single skip length wrong");
	a_skip_two: assert property (instr_done_o && s_reg.skipped && s_reg.two_word
		|-> idle_slot_o [*8] ##1 !idle_slot_o) // [RQ12]
		else $error("double skip length wrong");
	a_adj_low: assert property (instr_done_o && op_dec_adj && $past(s_reg.acc[3:0]) > 4'h9
		|-> s_reg.acc[3:0] == 4'($past(s_reg.acc[3:0]) + 4'h6)) // [RQ13]
		else $error("low nibble adjust wrong");
	a_adj_flags: assert property (instr_done_o && op_dec_adj
		|-> s_reg.stat[4:1] == $past(s_reg.stat[4:1]) && s_reg.cycles == 2'h1) // [RQ15]
		else $error("decimal adjust touched flags");

	c_wd_clear: cover property (watchdog_clear_o);
	c_compl_file: cover property (mem_we && !is_idle);
	c_skip_two: cover property (instr_done_o && s_reg.cycles == 2'h3);
	c_adj_carry: cover property (instr_done_o && op_dec_adj && s_reg.stat[cwd_pkg::ST_C]);
endmodule // cwd_exec_core

//--- verif/test_cpu_watchdog_compare_bcd_ops.sv
// self-checking bench for the instruction execution block
`timescale 1ns/1ns
module test_cpu_watchdog_compare_bcd_ops;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic watchdog_clear_o;
	logic postscaler_clear_o;
	logic instr_done_o;
	logic idle_slot_o;
	logic busy_o;
	int miscompares = 0;
	int samples_checked = 0;
	int idle_cnt = 0;
	int done_cnt = 0;
	int wd_cnt = 0;
	int idle_d;
	int wd_d;
	logic [31:0] rd;
	logic err;

	cwd_exec_core i_cwd_exec_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .watchdog_clear_o(watchdog_clear_o),
		.postscaler_clear_o(postscaler_clear_o), .instr_done_o(instr_done_o),
		.idle_slot_o(idle_slot_o), .busy_o(busy_o));

	////////////////////////////////////////////////////////////////////////////////
	// clock, pulse counters, watchdog
	initial forever #20 clk_i = ~clk_i;

	always @(negedge clk_i)
	begin
		if (idle_slot_o === 1'b1)
			idle_cnt++;
		if (instr_done_o === 1'b1)
			done_cnt++;
		if (watchdog_clear_o === 1'b1 && postscaler_clear_o === 1'b1)
			wd_cnt++;
	end

	// run needs well under a thousand cycles; this is well past that
	initial
	begin
		#2000000;
		miscompares++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus and check tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// answer is taken at the rising edge that sees pready high
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 20);
		rd = prdata_o;
		err = pslverr_o;
		if (pready_o !== 1'b1)
			chk({31'h0, pready_o}, 32'h1);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk({31'h0, err}, 32'h0);
		chk(rd, exp);
	endtask

	task automatic mput(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, cwd_pkg::REG_MADDR, {20'h0, a});
		apb(1'b1, cwd_pkg::REG_MDATA, {24'h0, d});
	endtask

	task automatic mchk(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b1, cwd_pkg::REG_MADDR, {20'h0, a});
		rchk(cwd_pkg::REG_MDATA, {24'h0, exp});
	endtask

	// start one word and poll until the block is idle again
	task automatic run(input logic [15:0] w, input logic [1:0] cyc);
		int n;
		int d0;
		int i0;
		int w0;
		n = 0;
		d0 = done_cnt;
		i0 = idle_cnt;
		w0 = wd_cnt;
		apb(1'b1, cwd_pkg::REG_INSTR, {16'h0, w});
		do
		begin
			apb(1'b0, cwd_pkg::REG_STATE, 32'h0);
			if (n == 0)
				chk({31'h0, busy_o}, 32'h1);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 40);
		idle_d = idle_cnt - i0;
		wd_d = wd_cnt - w0;
		chk({31'h0, rd[0]}, 32'h0);
		chk({31'h0, busy_o}, 32'h0);
		chk(32'(done_cnt - d0), 32'h1);
		chk({30'h0, rd[3:2]}, {30'h0, cyc});
	endtask

	task automatic cmp(input logic [6:0] op, input logic [7:0] r, input logic [7:0] w,
		input logic sk, input logic two);
		apb(1'b1, cwd_pkg::REG_CTRL, {30'h0, two, 1'b0});
		apb(1'b1, cwd_pkg::REG_ACCUM, {24'h0, w});
		mput(12'h345, r);
		apb(1'b1, cwd_pkg::REG_STATUS, 32'h15);
		run({op, 1'b1, 8'h45}, sk ? (two ? 2'h3 : 2'h2) : 2'h1);
		chk({31'h0, rd[1]}, {31'h0, sk});
		chk(32'(idle_d), sk ? (two ? 32'h8 : 32'h4) : 32'h0);
		rchk(cwd_pkg::REG_STATUS, 32'h15);
		rchk(cwd_pkg::REG_ACCUM, {24'h0, w});
	endtask

	task automatic dec_adj(input logic [7:0] a, input logic c, input logic dc,
		input logic [7:0] ea, input logic ec);
		apb(1'b1, cwd_pkg::REG_ACCUM, {24'h0, a});
		apb(1'b1, cwd_pkg::REG_STATUS, {27'h0, 3'b101, dc, c});
		run(cwd_pkg::OPC_DEC_ADJ, 2'h1);
		rchk(cwd_pkg::REG_ACCUM, {24'h0, ea});
		rchk(cwd_pkg::REG_STATUS, {27'h0, 3'b101, dc, ec});
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// test sequence
	logic [11:0] ph[5] = '{12'h020, 12'hf90, 12'h230, 12'h25f, 12'h060};
	logic [7:0] fa[5] = '{8'h20, 8'h90, 8'h30, 8'h5f, 8'h60};
	logic ext[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rchk(cwd_pkg::REG_POWER, 32'h3);
		// watchdog clear sets both flags again
		apb(1'b1, cwd_pkg::REG_POWER, 32'h0);
		run(cwd_pkg::OPC_WD_CLEAR, 2'h1);
		chk(32'(wd_d), 32'h1);
		rchk(cwd_pkg::REG_POWER, 32'h3);
		// complement into accumulator, then back into the file
		apb(1'b1, cwd_pkg::REG_BANK, 32'h3);
		mput(12'h345, 8'h13);
		apb(1'b1, cwd_pkg::REG_STATUS, 32'h0b);
		run({6'h07, 2'b01, 8'h45}, 2'h1);
		rchk(cwd_pkg::REG_ACCUM, 32'hec);
		rchk(cwd_pkg::REG_STATUS, 32'h1b);
		mchk(12'h345, 8'h13);
		mput(12'h345, 8'hff);
		run({6'h07, 2'b11, 8'h45}, 2'h1);
		mchk(12'h345, 8'h00);
		rchk(cwd_pkg::REG_STATUS, 32'h0f);
		rchk(cwd_pkg::REG_ACCUM, 32'hec);
		// access bank, upper access half and indexed offset around 5fh
		apb(1'b1, cwd_pkg::REG_IBASE, 32'h200);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, cwd_pkg::REG_CTRL, {31'h0, ext[i]});
			mput(ph[i], 8'h3c ^ 8'(i));
			run({6'h07, 2'b10, fa[i]}, 2'h1);
			mchk(ph[i], ~(8'h3c ^ 8'(i)));
		end
		// compares, unsigned, skip and no skip
		cmp(cwd_pkg::OPC_CMP_EQ, 8'h55, 8'h55, 1'b1, 1'b0);
		cmp(cwd_pkg::OPC_CMP_EQ, 8'h55, 8'h56, 1'b0, 1'b0);
		cmp(cwd_pkg::OPC_CMP_GT, 8'h80, 8'h7f, 1'b1, 1'b0);
		cmp(cwd_pkg::OPC_CMP_GT, 8'h55, 8'h55, 1'b0, 1'b0);
		cmp(cwd_pkg::OPC_CMP_LT, 8'h7f, 8'h80, 1'b1, 1'b0);
		cmp(cwd_pkg::OPC_CMP_LT, 8'h55, 8'h55, 1'b0, 1'b0);
		cmp(cwd_pkg::OPC_CMP_LT, 8'h00, 8'h01, 1'b1, 1'b1);
		cmp(cwd_pkg::OPC_CMP_EQ, 8'h01, 8'h00, 1'b0, 1'b1);
		// decimal adjust
		dec_adj(8'ha5, 1'b0, 1'b0, 8'h05, 1'b1);
		dec_adj(8'hce, 1'b0, 1'b0, 8'h34, 1'b1);
		dec_adj(8'h3c, 1'b0, 1'b0, 8'h42, 1'b0);
		dec_adj(8'h12, 1'b1, 1'b0, 8'h72, 1'b1);
		dec_adj(8'h34, 1'b0, 1'b1, 8'h3a, 1'b0);
		dec_adj(8'h0a, 1'b0, 1'b0, 8'h10, 1'b0);
		// refused transfers
		apb(1'b1, cwd_pkg::REG_STATE, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 8'h28, 32'h0);
		chk({31'h0, err}, 32'h1);
		results();
	end
endmodule // test_cpu_watchdog_compare_bcd_ops
